// [design/swbp_pkg.sv]
// Purpose: constants, carriers and decode shared by the write burst path
// Assumes: pclk at 100 MHz, link pins sampled through three flip-flops
// Notes: register map offsets are byte addresses on a 32-bit APB
package swbp_pkg;
	localparam int DQ_W = 16;
	localparam int MASK_W = DQ_W / 8;
	localparam int ADDR_W = 14;
	localparam int COL_W = 10;
	localparam int BSEL_BIT = 12;
	localparam int AP_BIT = 10;
	localparam int LAT_W = 4;
	localparam int BEAT_W = 4;
	localparam int CNT_W = 8;
	localparam int STALL_W = 3;
	localparam logic [BEAT_W-1:0] BEATS_FULL = 4'h8;
	localparam logic [BEAT_W-1:0] BEATS_CHOP = 4'h4;
	localparam logic [STALL_W-1:0] STALL_CK = 3'h2;
	// Burst length field encodings of mode register zero
	localparam logic [1:0] BL_FIXED8 = 2'h0;
	localparam logic [1:0] BL_PER_CMD = 2'h1;
	localparam logic [1:0] BL_FIXED4 = 2'h2;
	// Command code {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_WRITE = 4'h4;
	localparam logic [3:0] CMD_READ = 4'h5;
	// Register byte offsets
	localparam logic [7:0] OFF_MODE0 = 8'h00;
	localparam logic [7:0] OFF_MODE1 = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_MEM_IDX = 8'h0C;
	localparam logic [7:0] OFF_MEM_DATA = 8'h10;
	// Field positions and reset values
	localparam int M0_BL_LSB = 0;
	localparam int M0_COLLAT_LSB = 4;
	localparam int M0_ADDLAT_LSB = 8;
	localparam int M1_TS_BIT = 11;
	localparam logic [31:0] MODE0_RST = 32'h0000_0050;
	localparam logic [31:0] MODE1_RST = 32'h0000_0000;

	typedef struct packed {
		logic ck;
		logic [3:0] cmd;
		logic [ADDR_W-1:0] addr;
		logic dqs;
		logic [DQ_W-1:0] dq;
		logic [MASK_W-1:0] mask;
	} swbp_pins_t;

	typedef struct packed {
		logic valid;
		logic chop;
		logic [COL_W-1:0] col;
	} swbp_wreq_t;

	typedef enum logic {BS_IDLE, BS_BURST} swbp_state_t;

	// Burst chop decision from length field and select bit
	function automatic logic swbp_is_chop(logic [1:0] bl, logic bsel);
		return (bl == BL_FIXED4) || ((bl == BL_PER_CMD) && !bsel);
	endfunction
endpackage

// [design/swbp_sync.sv]
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs come from outside the pclk domain
// Notes: output moves only when the second and third stages agree
`timescale 1ns/1ns
module swbp_sync #(
	parameter int W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	import swbp_pkg::*;

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] q_q;
	wire logic [W-1:0] agree;

	// Bits whose later stages match
	assign agree = ~(s2_q ^ s3_q);
	assign q = q_q;

	// Sampling chain and filtered level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			q_q <= '0;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			q_q <= (s2_q & agree) | (q_q & ~agree);
		end
	end
endmodule

// [design/swbp_top.sv]
// Purpose: device-side write burst capture with length modes and masking
// Assumes: link clock and pins far slower than pclk, sampled by pclk
// Notes: stored data is read back over APB through an index register
`timescale 1ns/1ns
module swbp_top #(
	parameter int MAX_WR_LAT = 16,
	parameter int MEM_DEPTH = 32,
	parameter bit ORG_X8 = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ck,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [swbp_pkg::ADDR_W-1:0] addr,
	input wire logic dqs,
	input wire logic [swbp_pkg::DQ_W-1:0] dq,
	input wire logic [swbp_pkg::MASK_W-1:0] write_byte_mask,
	output logic termination_strobe,
	output logic termination_strobe_oe
);
	import swbp_pkg::*;

	localparam int IW = $clog2(MAX_WR_LAT);
	localparam int MW = $clog2(MEM_DEPTH);

	////////////////////////////////////////////////////////////////////////
	// Pin sampling

	swbp_pins_t pins_raw;
	swbp_pins_t pins_s;
	logic ck_q;
	logic dqs_q;

	// Bundle pins so all share one synchroniser delay
	assign pins_raw = '{ck: ck, cmd: {cs_n, ras_n, cas_n, we_n},
		addr: addr, dqs: dqs, dq: dq, mask: write_byte_mask};

	swbp_sync #(.W($bits(swbp_pins_t))) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(pins_raw),
		.q(pins_s)
	);

	// Previous levels for edge finding
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ck_q <= 1'b0;
			dqs_q <= 1'b0;
		end else begin
			ck_q <= pins_s.ck;
			dqs_q <= pins_s.dqs;
		end
	end

	wire logic ck_rise = pins_s.ck & ~ck_q;
	wire logic dqs_edge = pins_s.dqs ^ dqs_q;
	wire logic dqs_rise = pins_s.dqs & ~dqs_q;

	////////////////////////////////////////////////////////////////////////
	// Registers and command decode

	logic [31:0] mode0_q;
	logic [31:0] mode1_q;
	logic [MW-1:0] mem_idx_q;
	logic [DQ_W-1:0] mem_q [MEM_DEPTH];
	logic wr_chop_q;
	logic rd_chop_q;
	logic ap_q;
	logic [CNT_W-1:0] wr_cnt_q;
	logic [CNT_W-1:0] abort_cnt_q;
	logic [31:0] prdata_q;

	wire logic [1:0] bl_mode = mode0_q[M0_BL_LSB +: 2];
	wire logic [LAT_W-1:0] col_lat = mode0_q[M0_COLLAT_LSB +: LAT_W];
	wire logic [LAT_W-1:0] add_lat = mode0_q[M0_ADDLAT_LSB +: LAT_W];
	// Termination strobe mode replaces mask on the x8 part
	wire logic ts_mode = ORG_X8 & mode1_q[M1_TS_BIT];

	wire logic is_wr = ck_rise & (pins_s.cmd == CMD_WRITE);
	wire logic is_rd = ck_rise & (pins_s.cmd == CMD_READ);
	wire logic bsel = pins_s.addr[BSEL_BIT];
	// Column taken below the select bit only
	wire logic [COL_W-1:0] cmd_col = pins_s.addr[COL_W-1:0];
	// Same decode for reads and writes, auto precharge bit not involved
	wire logic cmd_chop = swbp_is_chop(bl_mode, bsel);

	////////////////////////////////////////////////////////////////////////
	// Write latency pipeline

	swbp_wreq_t pipe_q [MAX_WR_LAT];
	wire logic [LAT_W:0] wr_lat = {1'b0, col_lat} + {1'b0, add_lat};
	wire logic [LAT_W:0] lat_m1 = (wr_lat == '0) ? '0 : wr_lat - 1'b1;
	wire logic [IW-1:0] lat_idx = (32'(lat_m1) > MAX_WR_LAT - 1) ?
		IW'(MAX_WR_LAT - 1) : IW'(lat_m1);
	wire swbp_wreq_t new_req = '{valid: is_wr, chop: cmd_chop, col: cmd_col};
	wire swbp_wreq_t launch_req = pipe_q[lat_idx];
	// Burst opens at the write latency edge
	wire logic launch = ck_rise & launch_req.valid;

	// Entry ages by one per link clock rising edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pipe_q[0] <= '0;
		end else if (ck_rise) begin
			pipe_q[0] <= new_req;
		end
	end

	for (genvar i = 1; i < MAX_WR_LAT; i++) begin : g_pipe
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				pipe_q[i] <= '0;
			end else if (ck_rise) begin
				pipe_q[i] <= pipe_q[i-1];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Burst capture

	swbp_state_t state_q;
	swbp_wreq_t burst_q;
	logic [BEAT_W-1:0] beat_q;
	logic [STALL_W-1:0] stall_q;

	wire logic active = (state_q == BS_BURST);
	// A silent strobe ends the burst so the path never hangs
	wire logic abort = active & ~launch & (stall_q == STALL_CK);
	wire swbp_wreq_t cur_req = launch ? launch_req : burst_q;
	wire logic [BEAT_W-1:0] cur_beat = launch ? '0 : beat_q;
	wire logic [BEAT_W-1:0] need = cur_req.chop ? BEATS_CHOP : BEATS_FULL;
	// Both strobe edges carry data, first beat on a rising edge
	wire logic beat_wr = (launch | active) & ~abort & dqs_edge &
		((cur_beat != '0) | dqs_rise);
	wire logic last_beat = beat_wr & (cur_beat == need - 1'b1);
	// Only the addressed eight-column group is ever touched
	wire logic [MW-1:0] widx = {cur_req.col[MW-1:3],
		cur_req.col[2] ^ cur_beat[2], cur_beat[1:0]};
	// Mask taken from the same sampled edge as data, writes only
	wire logic [MASK_W-1:0] mask_eff = ts_mode ? '0 : pins_s.mask;

	// Burst sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= BS_IDLE;
			burst_q <= '0;
			beat_q <= '0;
		end else if (launch) begin
			state_q <= BS_BURST;
			burst_q <= launch_req;
			beat_q <= beat_wr ? BEAT_W'(1) : '0;
		end else if (abort || last_beat) begin
			state_q <= BS_IDLE;
		end else if (beat_wr) begin
			beat_q <= beat_q + 1'b1;
		end
	end

	// Link clocks without a strobe edge while a burst is open
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stall_q <= '0;
		end else if (launch || beat_wr || !active) begin
			stall_q <= '0;
		end else if (ck_rise && stall_q != STALL_CK) begin
			stall_q <= stall_q + 1'b1;
		end
	end

	// Byte lanes stored unless masked; one process owns the whole array
	always_ff @(posedge pclk) begin
		for (int b = 0; b < MASK_W; b++) begin
			if (beat_wr && !mask_eff[b]) begin
				mem_q[widx][b*8 +: 8] <= pins_s.dq[b*8 +: 8];
			end
		end
	end

	// Completion, abort and last command records
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_cnt_q <= '0;
			abort_cnt_q <= '0;
			wr_chop_q <= 1'b0;
			rd_chop_q <= 1'b0;
			ap_q <= 1'b0;
		end else begin
			if (last_beat) begin
				wr_cnt_q <= wr_cnt_q + 1'b1;
			end
			if (abort || (launch && active)) begin
				abort_cnt_q <= abort_cnt_q + 1'b1;
			end
			if (is_wr) begin
				wr_chop_q <= cmd_chop;
			end
			if (is_rd) begin
				rd_chop_q <= cmd_chop;
			end
			if (is_wr || is_rd) begin
				ap_q <= pins_s.addr[AP_BIT];
			end
		end
	end

	// Termination strobe follows the sampled strobe during bursts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			termination_strobe <= 1'b0;
			termination_strobe_oe <= 1'b0;
		end else begin
			termination_strobe <= pins_s.dqs;
			termination_strobe_oe <= ts_mode & (launch | active);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB slave

	wire logic setup = psel & ~penable;
	wire logic access = psel & penable;
	wire logic hit_m0 = (paddr == OFF_MODE0);
	wire logic hit_m1 = (paddr == OFF_MODE1);
	wire logic hit_st = (paddr == OFF_STATUS);
	wire logic hit_ix = (paddr == OFF_MEM_IDX);
	wire logic hit_md = (paddr == OFF_MEM_DATA);
	wire logic hit_any = hit_m0 | hit_m1 | hit_st | hit_ix | hit_md;
	wire logic [31:0] status_w = {8'h00, abort_cnt_q, wr_cnt_q, 4'h0,
		ap_q, rd_chop_q, wr_chop_q, active};
	wire logic [31:0] rd_mux = hit_m0 ? mode0_q :
		hit_m1 ? mode1_q :
		hit_st ? status_w :
		hit_ix ? 32'(mem_idx_q) :
		hit_md ? 32'(mem_q[mem_idx_q]) : 32'h0000_0000;

	assign pready = 1'b1;
	assign pslverr = access & ~hit_any;
	assign prdata = prdata_q;

	// Register writes in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode0_q <= MODE0_RST;
			mode1_q <= MODE1_RST;
			mem_idx_q <= '0;
		end else if (access && pwrite) begin
			if (hit_m0) begin
				mode0_q <= pwdata;
			end
			if (hit_m1) begin
				mode1_q <= pwdata;
			end
			if (hit_ix) begin
				mem_idx_q <= pwdata[MW-1:0];
			end
		end
	end

	// Read data captured in the setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
		end else if (setup) begin
			prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [MW-1:0] chk_idx_q;
	logic [7:0] chk_old_q;
	logic chk_msk_q;
	wire logic [7:0] chk_old_byte = mem_q[widx][7:0];

	// Snapshot of a masked lane zero write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chk_idx_q <= '0;
			chk_old_q <= '0;
			chk_msk_q <= 1'b0;
		end else begin
			chk_idx_q <= widx;
			chk_old_q <= chk_old_byte;
			chk_msk_q <= beat_wr & mask_eff[0];
		end
	end

	sequence s_chop_last;
		active && burst_q.chop && beat_q == BEATS_CHOP - 1'b1 &&
			beat_wr && !launch;
	endsequence

	chk_fixed_chop_mode: assert property (
		is_wr && bl_mode == BL_FIXED4 |=> pipe_q[0].chop)
		else $error("fixed chop mode gave a full burst");
	chk_sel_chop_low: assert property (
		is_wr && bl_mode == BL_PER_CMD && !bsel |=> pipe_q[0].chop)
		else $error("select low did not chop");
	chk_full_burst_mode: assert property (
		is_wr && (bl_mode == BL_FIXED8 || (bl_mode == BL_PER_CMD && bsel))
		|=> !pipe_q[0].chop && pipe_q[0].valid)
		else $error("eight beat write was chopped");
	chk_col_excludes_select: assert property (
		is_wr |=> pipe_q[0].col == $past(pins_s.addr[COL_W-1:0]))
		else $error("column address changed by select bit");
	chk_read_sel_length: assert property (
		is_rd && bl_mode == BL_PER_CMD |=> rd_chop_q == !$past(bsel))
		else $error("read burst length wrong");
	chk_chop_four_beats: assert property (
		s_chop_last |=> state_q == BS_IDLE &&
			wr_cnt_q == $past(wr_cnt_q) + 1'b1)
		else $error("chopped burst did not end after four beats");
	chk_mask_blocks_byte: assert property (
		chk_msk_q |-> mem_q[chk_idx_q][7:0] == chk_old_q)
		else $error("masked byte was written");
	chk_launch_at_latency: assert property (
		launch |=> state_q == BS_BURST && burst_q == $past(launch_req))
		else $error("burst did not open at write latency");
	chk_stall_no_hang: assert property (
		abort |=> state_q == BS_IDLE &&
			abort_cnt_q == $past(abort_cnt_q) + 1'b1)
		else $error("stalled burst not released");
	chk_term_no_mask: assert property (
		ts_mode && beat_wr |=> mem_q[$past(widx)] == $past(pins_s.dq))
		else $error("termination strobe acted as mask");
endmodule

// [sim/swbp_ctrl_model.sv]
// Purpose: memory controller model driving the write link pins
// Assumes: link clock period 80 ns, strobe edges on clock edges
// Notes: clock stands still between frames, idle data lines wander
`timescale 1ns/1ns
module swbp_ctrl_model (
	output swbp_pkg::swbp_pins_t pins
);
	import swbp_pkg::*;
	int h;
	int j;
	////////////////////////////////////////////////////////////////////
	// Idle link: clock low, deselected
	initial begin
		pins = '0;
		pins.cmd = 4'hF;
	end
	// One command, then n strobe edges from the latency edge on
	task automatic xfer(input logic [3:0] c, input logic [13:0] a,
		input int lat, input int n, input logic [15:0] d,
		input logic [15:0] m);
		// Step off the pclk edge so no pin races its sampling
		#3;
		pins.cmd = c;
		pins.addr = a;
		#40 pins.ck = 1'b1;
		// Trailing clocks space commands and give recovery
		for (h = 1; h <= 2 * lat + 10; h++) begin
			j = h - 2 * lat;
			#20;
			if (j >= 0 && j < n) begin
				pins.dq = d ^ 16'(16'h1111 * j);
				pins.mask = m[2*j +: 2];
			end else begin
				pins.dq = ~pins.dq; // Released lines never hold
				pins.mask = ~pins.mask;
			end
			#20 pins.ck = ~h[0];
			pins.dqs = (j >= 0 && j < n) ? ~j[0] : 1'b0;
			if (h == 1) begin
				pins.cmd = 4'hF;
				pins.addr = ~a;
			end
		end
		#40 pins.ck = 1'b0;
	endtask
endmodule

// [sim/tb.sv]
// Purpose: self-checking bench for the write burst path
// Assumes: model drives the link, bench drives APB at pclk rise
// Notes: memory is checked word by word through the index register
`timescale 1ns/1ns
module tb;
	import swbp_pkg::*;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic ts;
	logic ts_oe;
	swbp_pins_t pins;
	int n_fail = 0;
	int n_tests = 0;
	int cyc = 0;
	logic [31:0] rd;
	logic err;
	logic [1:0] bls[4] = '{BL_FIXED8, BL_PER_CMD, BL_FIXED4, BL_PER_CMD};
	logic [3:0] sels = 4'b0110;
	logic [3:0] chps = 4'b1100;
	////////////////////////////////////////////////////////////////////
	swbp_ctrl_model ctrl (.pins(pins));
	swbp_top DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ck(pins.ck),
		.cs_n(pins.cmd[3]), .ras_n(pins.cmd[2]), .cas_n(pins.cmd[1]),
		.we_n(pins.cmd[0]), .addr(pins.addr), .dqs(pins.dqs), .dq(pins.dq),
		.write_byte_mask(pins.mask), .termination_strobe(ts),
		.termination_strobe_oe(ts_oe)
	);
	// Clock and hang guard
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_fail++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////////
	// Shared checks and bus cycles
	task automatic check(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic memw(input logic [31:0] i);
		apb(1'b1, OFF_MEM_IDX, i);
		apb(1'b0, OFF_MEM_DATA, '0);
	endtask
	function automatic logic [15:0] bd(input logic [15:0] d, input int i);
		return d ^ 16'(16'h1111 * i);
	endfunction
	function automatic logic [31:0] widx(input logic [4:0] c, input int i);
		return {27'h0, c[4:3], c[2] ^ i[2], i[1:0]};
	endfunction
	////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_regs();
		apb(1'b0, OFF_MODE0, '0);
		check("mode0", rd, MODE0_RST);
		apb(1'b0, OFF_MODE1, '0);
		check("mode1", rd, MODE1_RST);
		apb(1'b1, OFF_STATUS, 32'hFFFF_FFFF);
		apb(1'b0, OFF_STATUS, '0);
		check("status", rd, 32'h0);
		apb(1'b0, 8'h14, '0);
		check("unmapped", {err, rd[30:0]}, 32'h8000_0000);
		$display("regs done");
	endtask
	task automatic t_modes();
		logic [4:0] col;
		for (int k = 0; k < 4; k++) begin
			col = 5'(k * 8 + 4 * (k % 2));
			apb(1'b1, OFF_MODE0, MODE0_RST);
			ctrl.xfer(CMD_WRITE, 14'h1000 | 14'(col), 5, 8, 16'h0A00, '0);
			apb(1'b1, OFF_MODE0, MODE0_RST | 32'(bls[k]));
			ctrl.xfer(CMD_WRITE, {1'b0, sels[k], 1'b0, k[0], 5'h0, col},
				5, 8, 16'hB000, '0);
			for (int i = 0; i < 8; i++) begin
				memw(widx(col, i));
				check("word", rd, {16'h0, bd((chps[k] && i > 3) ? 16'h0A00 :
					16'hB000, i)});
			end
			apb(1'b0, OFF_STATUS, '0);
			check("wr_chop", 32'(rd[1]), 32'(chps[k]));
		end
		$display("modes done");
	endtask
	task automatic t_mask();
		logic [15:0] kp;
		apb(1'b1, OFF_MODE0, 32'h150);
		ctrl.xfer(CMD_WRITE, 14'h1000, 6, 8, 16'h1234, '0);
		ctrl.xfer(CMD_WRITE, 14'h1000, 6, 8, 16'hC0C0, 16'hE4E4);
		for (int i = 0; i < 8; i++) begin
			kp = {{8{i[1]}}, {8{i[0]}}};
			memw(widx(5'h0, i));
			check("masked", rd, {16'h0, (bd(16'h1234, i) & kp) |
				(bd(16'hC0C0, i) & ~kp)});
		end
		apb(1'b1, OFF_MODE0, MODE0_RST);
		$display("mask done");
	endtask
	task automatic t_term();
		logic tsp;
		int nt;
		tsp = 1'b0;
		nt = 0;
		apb(1'b1, OFF_MODE1, 32'h800);
		fork
			ctrl.xfer(CMD_WRITE, 14'h1000, 5, 8, 16'h5A5A, 16'hFFFF);
			// Watch the strobe copy over the whole burst
			for (int c = 0; c < 100; c++) begin
				@(posedge pclk);
				if (c == 64) begin
					check("term_oe", 32'(ts_oe), 32'h1);
				end
				nt += int'(ts !== tsp);
				tsp = ts;
			end
		join
		check("term_edges", 32'(nt), 32'd8);
		memw(32'h0);
		check("term_mask", rd, 32'h5A5A);
		check("term_off", 32'(ts_oe), 32'h0);
		apb(1'b1, OFF_MODE1, '0);
		$display("term done");
	endtask
	task automatic t_abort();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		ctrl.xfer(CMD_WRITE, 14'h1010, 5, 4, 16'h7E00, '0);
		apb(1'b0, OFF_STATUS, '0);
		check("stall", rd & 32'hFFFF01, 32'h010000);
		memw(32'd19);
		check("kept", rd, 32'h7E00 ^ 32'h3333);
		ctrl.xfer(CMD_WRITE, 14'h1018, 5, 8, 16'h3C00, '0);
		apb(1'b0, OFF_STATUS, '0);
		check("recover", rd & 32'hFFFF01, 32'h010100);
		$display("abort done");
	endtask
	task automatic t_read();
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, OFF_MODE0, MODE0_RST | 32'(bls[k]));
			ctrl.xfer(CMD_READ, {1'b0, sels[k], 1'b0, k[0], 10'h018},
				5, 0, 16'h0, 16'hFFFF);
			apb(1'b0, OFF_STATUS, '0);
			check("rd_mode", rd & 32'hC, {28'h0, k[0], chps[k], 2'h0});
		end
		memw(32'd24);
		check("rd_keeps", rd, 32'h3C00);
		$display("read done");
	endtask
	////////////////////////////////////////////////////////////////////
	// Verdict and main sequence
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		t_regs();
		t_modes();
		t_mask();
		t_term();
		t_abort();
		t_read();
		end_of_test();
	end
endmodule
